//--- core/mcadc_pkg.sv
// constants, register map and types for the multichannel converter acquisition control
package mcadc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACQ_TIME_NS = 1000;
    localparam int BIT_TIME_NS = 500;
    localparam int PACER_PERIOD_NS = 1000;
    localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int PACER_DIV = PACER_PERIOD_NS / CLK_PERIOD_NS;
    localparam int ADC_BITS = 12;
    localparam int RESULT_W = 16;
    localparam int CTR_W = 16;
    localparam int FIFO_DEPTH = 2048;
    localparam int PL_DEPTH = 2048;
    localparam int PL_AW = 11;
    localparam int CNT_W = 12;
    // register offsets
    localparam logic [3:0] OFS_RESULT = 4'h0;
    localparam logic [3:0] OFS_ACQ_CTRL = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_CHANNEL_GAIN_CONTROL = 4'h3;
    localparam logic [3:0] OFS_CHANNEL = 4'h4;
    localparam logic [3:0] OFS_DIO = 4'h5;
    localparam logic [3:0] OFS_CNT0 = 4'h6;
    localparam logic [3:0] OFS_CTR1 = 4'h7;
    localparam logic [3:0] OFS_CTR2 = 4'h8;
    localparam logic [3:0] OFS_PL_DATA = 4'h9;
    localparam logic [3:0] OFS_PL_CLEAR = 4'ha;
    // acquisition control fields
    localparam int ACQ_SRC_LSB = 0;
    localparam int ACQ_DIFF_BIT = 2;
    localparam int ACQ_IRQEN_BIT = 3;
    localparam int ACQ_BUF_BIT = 4;
    localparam int ACQ_FSEL_LSB = 5;
    localparam logic [6:0] ACQ_CTRL_RESET = 7'h00;
    localparam logic [6:0] CHANNEL_GAIN_CONTROL_RESET = 7'h00;
    localparam logic [1:0] SRC_SOFT = 2'h0;
    localparam logic [1:0] SRC_PACER = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] FSEL_HALF = 2'h0;
    localparam logic [1:0] FSEL_FULL = 2'h1;
    localparam logic [1:0] FSEL_NOT_EMPTY = 2'h2;
    typedef enum logic [1:0] {
        MCADC_IDLE = 2'b00,
        MCADC_ACQ = 2'b01,
        MCADC_CONV = 2'b11,
        MCADC_DONE = 2'b10
    } mcadc_state_type;
endpackage

//--- core/mcadc_fifo_if.sv
// handshake bundle between the acquisition control and its result store
`timescale 1ns/1ps
interface mcadc_fifo_if;
    import mcadc_pkg::*;
    logic [RESULT_W-1:0] wdata;
    logic wvalid;
    logic wready;
    logic [RESULT_W-1:0] rdata;
    logic rvalid;
    logic rready;
    logic [CNT_W:0] count;
    modport store (input wdata, input wvalid, output wready, output rdata, output rvalid, input rready, output count);
    modport ctrl (output wdata, output wvalid, input wready, input rdata, input rvalid, output rready, input count);
endinterface

//--- core/mcadc_fifo.sv
// result store: flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module mcadc_fifo import mcadc_pkg::*; #(
    parameter int WIDTH = RESULT_W,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int AW = PL_AW
) (
    input wire logic clk,
    input wire logic nrst,
    mcadc_fifo_if.store port
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CNT_W:0] count_reg;
    logic push;
    logic pop;

    assign port.wready = count_reg != (CNT_W+1)'(DEPTH);
    assign port.rvalid = count_reg != '0;
    assign port.rdata = mem[rd_ptr_reg];
    assign port.count = count_reg;
    assign push = port.wvalid && port.wready;
    assign pop = port.rready && port.rvalid;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= port.wdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

//--- core/mcadc_top.sv
// acquisition control: start sources, sar sequencer, counters, point list and result store
// Summary of operation
// - conversion starts by software command, pacer counter output, or external trigger pin.
// - each finished conversion sets an end-of-conversion flag, polled, or taken as interrupt outside buffered mode.
// - buffered mode has a 2K-sample result store and a 2K-entry point list.
// - result-store empty, half and full flags are readable; not-empty, half or full can raise the interrupt.
// - buffered mode takes channels from the point list and stores results unattended.
// - offset 3 holds four submux channel bits and three gain bits, driven out.
// - the submux channel bits form the top four bits of every result word.
// - twelve-bit successive approximation after a sample-and-hold acquisition.
// - one conversion completes well inside ten microseconds, above 100k per second.
// - software chooses eight differential or sixteen single-ended inputs.
// - three programmable sixteen-bit down counters; counter 2 is clocked by the terminal pulse of counter 1.
// - counter 0 counts an external clock up to 10 MHz, gated by a pin.
// - counters 1 and 2 cascade into 32 bits, first stage clocked at 1 MHz.
// - the cascaded pair output can be chosen as conversion pacer.
// - a software interrupt enable gates conversion-done and result-store interrupt requests.
// - four digital inputs and four digital outputs readable and writable by host.
// - counters decrement on the falling edge of their clock.
`timescale 1ns/1ps
module mcadc_top import mcadc_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] io_addr,
    input wire logic [15:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    output logic [15:0] io_rdata,
    output logic irq,
    input wire logic ext_trigger,
    input wire logic ext_counter_clk,
    input wire logic counter_zero_gate_pin,
    output logic cnt0_out,
    input wire logic [3:0] din,
    output logic [3:0] dout,
    output logic [3:0] mux_channel,
    output logic diff_mode,
    output logic [3:0] submux_channel_select,
    output logic [2:0] external_gain_code,
    output logic sh_hold,
    output logic [ADC_BITS-1:0] dac_code,
    input wire logic comparator_in
);
    mcadc_fifo_if fifo ();
    mcadc_fifo mcadc_fifo_inst (.clk(clk), .nrst(nrst), .port(fifo));

    mcadc_state_type state_reg;
    logic [6:0] acq_ctrl_reg;
    logic [6:0] channel_gain_control_reg;
    logic [3:0] channel_reg;
    logic [3:0] dout_reg;
    logic [3:0] conv_chan_reg;
    logic [ADC_BITS-1:0] sar_reg;
    logic [3:0] bit_idx_reg;
    logic [6:0] tmr_reg;
    logic [RESULT_W-1:0] result_reg;
    logic eoc_reg;
    logic irq_reg;
    logic [15:0] rdata_reg;
    logic ext_trig_d_reg;
    logic ext_clk_d_reg;
    logic [6:0] div_reg;
    logic [CTR_W-1:0] ctr_reload_reg [3];
    logic [CTR_W-1:0] ctr_cnt_reg [3];
    logic cnt0_out_reg;
    logic [3:0] pl_mem [PL_DEPTH];
    logic [PL_AW:0] pl_len_reg;
    logic [PL_AW-1:0] pl_rd_idx_reg;
    logic [2:0] ctr_tick;
    logic [2:0] ctr_term;
    logic [1:0] src;
    logic buffered;
    logic irq_en;
    logic mhz_en;
    logic ext_rise;
    logic ext_fall;
    logic sw_start;
    logic trig_req;
    logic accept;
    logic fifo_cond;
    logic pl_last;

    assign src = acq_ctrl_reg[ACQ_SRC_LSB +: 2];
    assign buffered = acq_ctrl_reg[ACQ_BUF_BIT];
    assign irq_en = acq_ctrl_reg[ACQ_IRQEN_BIT];
    assign ext_rise = ext_trigger && !ext_trig_d_reg;
    assign ext_fall = ext_clk_d_reg && !ext_counter_clk;
    assign sw_start = io_wr && io_addr == OFS_RESULT;
    assign mhz_en = div_reg == '0;
    assign pl_last = {1'b0, pl_rd_idx_reg} + 1'b1 >= pl_len_reg;

    // pacer request is the terminal pulse of the cascaded pair
    always_comb begin
        case (src)
            SRC_SOFT: trig_req = sw_start;
            SRC_PACER: trig_req = ctr_term[2];
            SRC_EXT: trig_req = ext_rise;
            default: trig_req = 1'b0;
        endcase
    end

    // a full store stalls new starts so no result is ever dropped
    assign accept = trig_req && state_reg == MCADC_IDLE && (!buffered || fifo.wready);

    assign fifo.wdata = {channel_gain_control_reg[3:0], sar_reg};
    assign fifo.wvalid = buffered && state_reg == MCADC_DONE;
    assign fifo.rready = buffered && io_rd && io_addr == OFS_RESULT;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ext_trig_d_reg <= 1'b0;
            ext_clk_d_reg <= 1'b0;
            div_reg <= '0;
        end else begin
            ext_trig_d_reg <= ext_trigger;
            ext_clk_d_reg <= ext_counter_clk;
            div_reg <= mhz_en ? 7'(PACER_DIV - 1) : div_reg - 1'b1;
        end
    end

    // each tick stands for a falling clock edge of that counter
    assign ctr_tick[0] = ext_fall && counter_zero_gate_pin;
    assign ctr_tick[1] = mhz_en;
    assign ctr_tick[2] = ctr_term[1];

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ctr_term[i] = ctr_tick[i] && ctr_cnt_reg[i] == 16'h0001;
        end
    end

    // a reload of zero parks the counter; it never reaches its terminal count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 3; i++) begin
                ctr_reload_reg[i] <= '0;
                ctr_cnt_reg[i] <= '0;
            end
            cnt0_out_reg <= 1'b0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (io_wr && io_addr == 4'(OFS_CNT0 + i)) begin
                    ctr_reload_reg[i] <= io_wdata;
                    ctr_cnt_reg[i] <= io_wdata;
                end else if (ctr_tick[i]) begin
                    ctr_cnt_reg[i] <= ctr_cnt_reg[i] <= 16'h0001 ? ctr_reload_reg[i] : ctr_cnt_reg[i] - 1'b1;
                end
            end
            cnt0_out_reg <= ctr_term[0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acq_ctrl_reg <= ACQ_CTRL_RESET;
            channel_gain_control_reg <= CHANNEL_GAIN_CONTROL_RESET;
            channel_reg <= '0;
            dout_reg <= '0;
        end else if (io_wr) begin
            case (io_addr)
                OFS_ACQ_CTRL: acq_ctrl_reg <= io_wdata[6:0];
                OFS_CHANNEL_GAIN_CONTROL: channel_gain_control_reg <= io_wdata[6:0];
                OFS_CHANNEL: channel_reg <= io_wdata[3:0];
                OFS_DIO: dout_reg <= io_wdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (io_wr && io_addr == OFS_PL_DATA && pl_len_reg != (PL_AW+1)'(PL_DEPTH)) begin
            pl_mem[pl_len_reg[PL_AW-1:0]] <= io_wdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pl_len_reg <= '0;
            pl_rd_idx_reg <= '0;
        end else if (io_wr && io_addr == OFS_PL_CLEAR) begin
            pl_len_reg <= '0;
            pl_rd_idx_reg <= '0;
        end else begin
            if (io_wr && io_addr == OFS_PL_DATA && pl_len_reg != (PL_AW+1)'(PL_DEPTH)) begin
                pl_len_reg <= pl_len_reg + 1'b1;
            end
            if (buffered && state_reg == MCADC_DONE) begin
                pl_rd_idx_reg <= pl_last ? '0 : pl_rd_idx_reg + 1'b1;
            end
        end
    end

    // sar sequencer: acquisition, then one trial per bit from the msb
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= MCADC_IDLE;
            tmr_reg <= '0;
            sar_reg <= '0;
            bit_idx_reg <= '0;
            conv_chan_reg <= '0;
        end else begin
            case (state_reg)
                MCADC_IDLE: begin
                    if (accept) begin
                        state_reg <= MCADC_ACQ;
                        tmr_reg <= 7'(ACQ_CYC - 1);
                        conv_chan_reg <= buffered ? pl_mem[pl_rd_idx_reg] : channel_reg;
                    end
                end
                MCADC_ACQ: begin
                    if (tmr_reg == '0) begin
                        state_reg <= MCADC_CONV;
                        tmr_reg <= 7'(BIT_CYC - 1);
                        sar_reg <= 12'h800;
                        bit_idx_reg <= 4'(ADC_BITS - 1);
                    end else begin
                        tmr_reg <= tmr_reg - 1'b1;
                    end
                end
                MCADC_CONV: begin
                    if (tmr_reg == '0) begin
                        sar_reg[bit_idx_reg] <= comparator_in;
                        tmr_reg <= 7'(BIT_CYC - 1);
                        if (bit_idx_reg == '0) begin
                            state_reg <= MCADC_DONE;
                        end else begin
                            sar_reg[bit_idx_reg - 1'b1] <= 1'b1;
                            bit_idx_reg <= bit_idx_reg - 1'b1;
                        end
                    end else begin
                        tmr_reg <= tmr_reg - 1'b1;
                    end
                end
                MCADC_DONE: state_reg <= MCADC_IDLE;
                default: state_reg <= MCADC_IDLE;
            endcase
        end
    end

    // a completion in the clearing cycle wins over the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result_reg <= '0;
            eoc_reg <= 1'b0;
        end else begin
            if (state_reg == MCADC_DONE) begin
                result_reg <= {channel_gain_control_reg[3:0], sar_reg};
                eoc_reg <= 1'b1;
            end else if ((io_rd && io_addr == OFS_RESULT) || (io_wr && io_addr == OFS_STATUS)) begin
                eoc_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        case (acq_ctrl_reg[ACQ_FSEL_LSB +: 2])
            FSEL_HALF: fifo_cond = fifo.count >= (CNT_W+1)'(FIFO_DEPTH / 2);
            FSEL_FULL: fifo_cond = !fifo.wready;
            FSEL_NOT_EMPTY: fifo_cond = fifo.rvalid;
            default: fifo_cond = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_en && (buffered ? fifo_cond : eoc_reg);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= '0;
        end else if (io_rd) begin
            case (io_addr)
                OFS_RESULT: rdata_reg <= buffered ? fifo.rdata : result_reg;
                OFS_ACQ_CTRL: rdata_reg <= {9'h000, acq_ctrl_reg};
                OFS_STATUS: rdata_reg <= {10'h000, irq_reg, !fifo.wready,
                    fifo.count >= (CNT_W+1)'(FIFO_DEPTH / 2), !fifo.rvalid, state_reg != MCADC_IDLE, eoc_reg};
                OFS_CHANNEL_GAIN_CONTROL: rdata_reg <= {9'h000, channel_gain_control_reg};
                OFS_CHANNEL: rdata_reg <= {12'h000, channel_reg};
                OFS_DIO: rdata_reg <= {12'h000, din};
                OFS_CNT0: rdata_reg <= ctr_cnt_reg[0];
                OFS_CTR1: rdata_reg <= ctr_cnt_reg[1];
                OFS_CTR2: rdata_reg <= ctr_cnt_reg[2];
                OFS_PL_CLEAR: rdata_reg <= {4'h0, pl_len_reg};
                default: rdata_reg <= '0;
            endcase
        end
    end

    assign io_rdata = rdata_reg;
    assign irq = irq_reg;
    assign cnt0_out = cnt0_out_reg;
    assign dout = dout_reg;
    assign mux_channel = conv_chan_reg;
    assign diff_mode = acq_ctrl_reg[ACQ_DIFF_BIT];
    assign submux_channel_select = channel_gain_control_reg[3:0];
    assign external_gain_code = channel_gain_control_reg[6:4];
    assign sh_hold = state_reg == MCADC_CONV;
    assign dac_code = sar_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_start_only_idle: assert property ($rose(state_reg == MCADC_ACQ) |-> $past(state_reg) == MCADC_IDLE)
        else $error("conversion started while busy");
    a_conv_time_bound: assert property (accept |-> ##[699:703] state_reg == MCADC_DONE)
        else $error("conversion did not finish in time");
    a_eoc_after_done: assert property (state_reg == MCADC_DONE |=> eoc_reg)
        else $error("end of conversion flag not set");
    a_result_tag_bits: assert property (state_reg == MCADC_DONE
        |=> result_reg[15:12] == $past(channel_gain_control_reg[3:0]))
        else $error("result tag differs from submux field");
    a_pacer_cascade: assert property (ctr_term[2] && !(io_wr && io_addr == OFS_CTR2)
        |=> ctr_cnt_reg[2] == $past(ctr_reload_reg[2]))
        else $error("pacer stage did not reload at its terminal count");
    a_irq_disabled_low: assert property (!irq_en |=> !irq)
        else $error("interrupt raised while disabled");
    a_store_accepts_result: assert property (buffered && state_reg == MCADC_DONE |-> fifo.wvalid && fifo.wready)
        else $error("result lost in buffered mode");
    a_pl_index_wrap: assert property (buffered && state_reg == MCADC_DONE && pl_last
        && !(io_wr && io_addr == OFS_PL_CLEAR) |=> pl_rd_idx_reg == '0)
        else $error("point list index did not wrap");
    a_dout_follows_write: assert property (io_wr && io_addr == OFS_DIO |=> dout == $past(io_wdata[3:0]))
        else $error("digital output not updated");
    a_cnt0_gated_hold: assert property (!counter_zero_gate_pin && !(io_wr && io_addr == OFS_CNT0)
        |=> ctr_cnt_reg[0] == $past(ctr_cnt_reg[0]))
        else $error("counter 0 moved while gated off");
    a_gain_out_field: assert property (io_wr && io_addr == OFS_CHANNEL_GAIN_CONTROL
        |=> external_gain_code == $past(io_wdata[6:4]))
        else $error("gain code not driven out");

    c_pacer_start: cover property (src == SRC_PACER && accept);
    c_ext_start: cover property (src == SRC_EXT && accept);
    c_buffered_done: cover property (buffered && state_reg == MCADC_DONE && pl_last);
    c_irq_raised: cover property (irq);
endmodule

//--- testbench/mcadc_host_model.sv
// host-side model: register accesses with one-cycle strobes, and end-of-conversion polling
`timescale 1ns/1ps
module mcadc_host_model import mcadc_pkg::*; (
    input wire logic clk,
    output logic [3:0] io_addr,
    output logic [15:0] io_wdata,
    output logic io_wr,
    output logic io_rd,
    input wire logic [15:0] io_rdata
);
    initial begin
        io_addr = 4'h0;
        io_wdata = 16'h0000;
        io_wr = 1'b0;
        io_rd = 1'b0;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk);
        #1;
        io_wr = 1'b0;
        // stale data is inverted so a late capture cannot look right
        io_wdata = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        #1;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge clk);
        #1;
        io_rd = 1'b0;
        d = io_rdata;
    endtask
    // each poll costs two cycles, so the bound covers a pacer wait plus a conversion
    task automatic wait_eoc(output logic ok);
        logic [15:0] s;
        ok = 1'b0;
        for (int i = 0; i < 800 && !ok; i++) begin
            rd(OFS_STATUS, s);
            ok = (s[0] === 1'b1);
        end
    endtask
endmodule

//--- testbench/mcadc_top_bench.sv
// self-checking bench for the acquisition control block
`timescale 1ns/1ps
module mcadc_top_bench import mcadc_pkg::*; ;
    logic clk, nrst, io_wr, io_rd, irq, ext_trigger, ext_counter_clk, counter_zero_gate_pin;
    logic cnt0_out, diff_mode, sh_hold, comparator_in, ok;
    logic [3:0] io_addr, din, dout, mux_channel, submux_channel_select;
    logic [2:0] external_gain_code;
    logic [15:0] io_wdata, io_rdata, v;
    logic [11:0] dac_code, analog_level;
    int err_count, num_checks, pulse_count, cyc, t0;

    mcadc_host_model mcadc_host_model_inst (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata));
    mcadc_top mcadc_top_inst (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .irq(irq), .ext_trigger(ext_trigger),
        .ext_counter_clk(ext_counter_clk), .counter_zero_gate_pin(counter_zero_gate_pin),
        .cnt0_out(cnt0_out), .din(din), .dout(dout), .mux_channel(mux_channel), .diff_mode(diff_mode),
        .submux_channel_select(submux_channel_select), .external_gain_code(external_gain_code),
        .sh_hold(sh_hold), .dac_code(dac_code), .comparator_in(comparator_in));

    // ideal comparator: the trial code settles on the analog level exactly
    assign comparator_in = (analog_level >= dac_code);
    initial clk = 1'b0;
    always #5 clk = ~clk;
    // counted on the falling edge, away from the edge that launches the pulse
    always @(negedge clk) begin
        cyc++;
        if (cnt0_out === 1'b1) begin
            pulse_count++;
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic eoc_wait();
        mcadc_host_model_inst.wait_eoc(ok);
        if (!ok) begin
            err_count++;
            $display("Error eoc wait expected 1 seen 0");
            stop_test();
        end
    endtask
    task automatic t_regs();
        mcadc_host_model_inst.rd(OFS_CHANNEL_GAIN_CONTROL, v);
        chk("channel gain reset", 16'h0000, v);
        mcadc_host_model_inst.wr(OFS_CHANNEL_GAIN_CONTROL, 16'h0057);
        chk("submux", 16'h0007, {12'h000, submux_channel_select});
        chk("gain", 16'h0005, {13'h0000, external_gain_code});
        mcadc_host_model_inst.rd(OFS_CHANNEL_GAIN_CONTROL, v);
        chk("channel gain read", 16'h0057, v);
        mcadc_host_model_inst.wr(4'hf, 16'hffff);
        mcadc_host_model_inst.rd(4'hf, v);
        chk("unmapped", 16'h0000, v);
        mcadc_host_model_inst.wr(OFS_ACQ_CTRL, 16'h0004);
        chk("diff on", 16'h0001, {15'h0000, diff_mode});
        mcadc_host_model_inst.wr(OFS_ACQ_CTRL, 16'h0000);
        chk("diff off", 16'h0000, {15'h0000, diff_mode});
        din = 4'ha;
        mcadc_host_model_inst.wr(OFS_DIO, 16'h0005);
        chk("dout", 16'h0005, {12'h000, dout});
        mcadc_host_model_inst.rd(OFS_DIO, v);
        chk("din", 16'h000a, v);
    endtask
    task automatic t_basic();
        analog_level = 12'habc;
        mcadc_host_model_inst.wr(OFS_CHANNEL, 16'h0009);
        t0 = cyc;
        mcadc_host_model_inst.wr(OFS_RESULT, 16'h0000);
        repeat (4) @(posedge clk);
        chk("mux channel", 16'h0009, {12'h000, mux_channel});
        repeat (200) @(posedge clk);
        chk("hold", 16'h0001, {15'h0000, sh_hold});
        // a second start in mid-conversion must leave no trace
        mcadc_host_model_inst.wr(OFS_RESULT, 16'h0000);
        eoc_wait();
        chk("throughput", 16'h0001, {15'h0000, (cyc - t0) < 1000});
        mcadc_host_model_inst.rd(OFS_RESULT, v);
        chk("result", 16'h7abc, v);
        mcadc_host_model_inst.rd(OFS_STATUS, v);
        chk("idle after one", 16'h0000, {14'h0000, v[1:0]});
    endtask
    task automatic t_ext_irq();
        analog_level = 12'h123;
        mcadc_host_model_inst.wr(OFS_ACQ_CTRL, 16'h000a);
        ext_trigger = 1'b1;
        repeat (3) @(posedge clk);
        #1 ext_trigger = 1'b0;
        eoc_wait();
        repeat (2) @(posedge clk);
        chk("irq set", 16'h0001, {15'h0000, irq});
        mcadc_host_model_inst.rd(OFS_RESULT, v);
        chk("ext result", 16'h7123, v);
        repeat (3) @(posedge clk);
        chk("irq clear", 16'h0000, {15'h0000, irq});
        mcadc_host_model_inst.wr(OFS_ACQ_CTRL, 16'h0000);
    endtask
    task automatic t_cnt0();
        mcadc_host_model_inst.wr(OFS_CNT0, 16'h0003);
        for (int g = 0; g < 2; g++) begin
            counter_zero_gate_pin = g[0];
            pulse_count = 0;
            repeat (6) begin
                #100 ext_counter_clk = 1'b1;
                #100 ext_counter_clk = 1'b0;
            end
            repeat (10) @(posedge clk);
            chk("cnt0 pulses", 16'(2 * g), 16'(pulse_count));
        end
        mcadc_host_model_inst.wr(OFS_CNT0, 16'h0000);
    endtask
    task automatic t_pacer();
        analog_level = 12'h456;
        mcadc_host_model_inst.wr(OFS_CTR1, 16'h0002);
        mcadc_host_model_inst.wr(OFS_CTR2, 16'h0002);
        mcadc_host_model_inst.wr(OFS_ACQ_CTRL, 16'h0001);
        eoc_wait();
        mcadc_host_model_inst.rd(OFS_RESULT, v);
        chk("pacer result", 16'h7456, v);
        mcadc_host_model_inst.wr(OFS_ACQ_CTRL, 16'h0000);
        mcadc_host_model_inst.wr(OFS_CTR1, 16'h0000);
        repeat (800) @(posedge clk);
        mcadc_host_model_inst.wr(OFS_STATUS, 16'h0000);
    endtask
    task automatic t_buffered();
        mcadc_host_model_inst.wr(OFS_PL_CLEAR, 16'h0000);
        mcadc_host_model_inst.wr(OFS_PL_DATA, 16'h0001);
        mcadc_host_model_inst.wr(OFS_PL_DATA, 16'h0002);
        mcadc_host_model_inst.rd(OFS_PL_CLEAR, v);
        chk("list length", 16'h0002, v);
        mcadc_host_model_inst.wr(OFS_ACQ_CTRL, 16'h0058);
        mcadc_host_model_inst.rd(OFS_STATUS, v);
        chk("store empty", 16'h0001, {15'h0000, v[2]});
        chk("irq empty", 16'h0000, {15'h0000, irq});
        for (int i = 0; i < 3; i++) begin
            analog_level = 12'(12'h100 * (i + 1) + i);
            mcadc_host_model_inst.wr(OFS_RESULT, 16'h0000);
            repeat (4) @(posedge clk);
            chk("list channel", 16'((i % 2) + 1), {12'h000, mux_channel});
            eoc_wait();
            mcadc_host_model_inst.wr(OFS_STATUS, 16'h0000);
        end
        repeat (2) @(posedge clk);
        chk("irq not empty", 16'h0001, {15'h0000, irq});
        mcadc_host_model_inst.rd(OFS_STATUS, v);
        chk("store flags", 16'h0008, {12'h000, v[5:2]});
        mcadc_host_model_inst.wr(OFS_ACQ_CTRL, 16'h0078);
        repeat (2) @(posedge clk);
        chk("irq select none", 16'h0000, {15'h0000, irq});
        mcadc_host_model_inst.wr(OFS_ACQ_CTRL, 16'h0058);
        for (int i = 0; i < 3; i++) begin
            mcadc_host_model_inst.rd(OFS_RESULT, v);
            chk("store word", {4'h7, 12'(12'h100 * (i + 1) + i)}, v);
        end
        mcadc_host_model_inst.rd(OFS_STATUS, v);
        chk("drained", 16'h0001, {15'h0000, v[2]});
        repeat (3) @(posedge clk);
        chk("irq drained", 16'h0000, {15'h0000, irq});
    endtask
    // a reset in mid-run must bring the registers back to their reset values
    task automatic t_reset();
        mcadc_host_model_inst.wr(OFS_DIO, 16'h000f);
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        chk("dout after reset", 16'h0000, {12'h000, dout});
        mcadc_host_model_inst.rd(OFS_CHANNEL_GAIN_CONTROL, v);
        chk("channel gain after reset", 16'h0000, v);
        mcadc_host_model_inst.rd(OFS_PL_CLEAR, v);
        chk("list length after reset", 16'h0000, v);
    endtask

    initial begin
        nrst = 1'b0;
        ext_trigger = 1'b0;
        ext_counter_clk = 1'b0;
        counter_zero_gate_pin = 1'b0;
        din = 4'h0;
        analog_level = 12'h000;
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        t_regs();
        t_basic();
        t_ext_irq();
        t_cnt0();
        t_pacer();
        t_buffered();
        t_reset();
        stop_test();
    end
    initial begin
        #500000;
        err_count++;
        stop_test();
    end
endmodule
